// file: hw/tx_bp_pkg.sv
// Constants, register layout and carrier types for the transmit backplane control.
// Assumes a 250 MHz ref_clk and a 32-bit AXI4-Lite register bus.
package tx_bp_pkg;

  // ----------------------------------------------------------------------
  // Register map (printed offsets are indices; byte address is four times)
  // ----------------------------------------------------------------------
  localparam logic [11:0] TIC_INDEX = 12'h120;
  localparam logic [11:0] FSEL_INDEX = 12'h109;
  localparam logic [11:0] STAT_INDEX = 12'h122;
  localparam logic [11:0] PINCFG_INDEX = 12'h123;
  localparam logic [13:0] TIC_ADDR = {TIC_INDEX, 2'b00};
  localparam logic [13:0] FSEL_ADDR = {FSEL_INDEX, 2'b00};
  localparam logic [13:0] STAT_ADDR = {STAT_INDEX, 2'b00};
  localparam logic [13:0] PINCFG_ADDR = {PINCFG_INDEX, 2'b00};
  localparam int ADDR_W = 14;

  localparam logic [7:0] TIC_RESET = 8'h00;
  localparam logic [7:0] FSEL_RESET = 8'h00;
  localparam logic [7:0] PINCFG_RESET = 8'h00;
  localparam int FSEL_SUPER_BIT = 5;
  localparam int PINCFG_CLKOUT_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {MODE_00, MODE_01, MODE_10, MODE_11} if_mode_t;

  typedef struct packed {
    logic syncFrac;
    logic rsvd;
    logic syncLowOrPayload;
    logic fracEn;
    logic clkInv;
    logic muxEn;
    if_mode_t mode;
  } tic_t;

  // Word handed to the transmit framer for every backplane bit taken.
  typedef struct packed {
    logic dataBit;
    logic sigBit;
    logic fracBit;
    logic [1:0] chan;
    logic frameStart;
    logic superStart;
  } bp_word_t;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int REF_PERIOD_PS = 4000;
  localparam int SERCLK_PERIOD_PS = 647668;
  localparam int FAST_PERIOD_PS = 31250;
  localparam int SERCLK_HALF = SERCLK_PERIOD_PS / (2 * REF_PERIOD_PS);
  localparam int FAST_HALF = (FAST_PERIOD_PS + REF_PERIOD_PS) / (2 * REF_PERIOD_PS);
  localparam logic [7:0] SERCLK_HALF_CNT = 8'(SERCLK_HALF - 1);
  localparam logic [7:0] FAST_HALF_CNT = 8'(FAST_HALF - 1);

  // Bits from the frame sync rise to the first bit of a frame, per mux mode.
  localparam logic [10:0] LEAD_BITMUX = 11'h000;
  localparam logic [10:0] LEAD_HMVIP = 11'h7FE;
  localparam logic [10:0] LEAD_H100 = 11'h7FF;

endpackage

// file: hw/tx_backplane_mode_control.sv
// Transmit backplane mode control of one T1 framer channel, with AXI4-Lite registers.
// Assumes backplane pins are asynchronous to ref_clk and much slower than it.
`timescale 1ns/1ns

module tx_backplane_mode_control
  import tx_bp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txSerialClockIn,
  output logic txSerialClockOut,
  output logic txSerialClockOe,
  input wire logic txMultiframeSync,
  input wire logic txFrameSync,
  input wire logic txSerialData,
  input wire logic [4:0] timeslotIdIn,
  output logic [4:0] timeslotIdOut,
  output logic [4:0] timeslotIdOe,
  input wire logic [4:0] framerChanNum,
  input wire logic framerOverheadBit,
  input wire logic framerMultiframeFirst,
  output bp_word_t bpWord,
  output logic bpWordValid
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  tic_t tic_r;
  logic [7:0] fsel_r;
  logic [7:0] pinCfg_r;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire logic baseRate = !tic_r.muxEn && (tic_r.mode == MODE_00);
  wire logic highSpeed = !tic_r.muxEn && (tic_r.mode != MODE_00);
  wire logic muxReserved = tic_r.muxEn && (tic_r.mode == MODE_01);
  wire logic muxByte = tic_r.muxEn && tic_r.mode[1];
  wire logic fracActive = tic_r.fracEn && baseRate;
  wire logic syncLow = !baseRate && tic_r.syncLowOrPayload;
  wire logic payloadClk = baseRate && tic_r.syncLowOrPayload;
  wire logic superSel = fsel_r[FSEL_SUPER_BIT];

  // ----------------------------------------------------------------------
  // Pin synchronisers: bit order serClk, msync, fsync, data, ts0, ts1
  // ----------------------------------------------------------------------
  logic [5:0] pinMeta_r;
  logic [5:0] pinSync_r;
  logic [5:0] pinPrev_r;
  wire logic [5:0] pinRaw = {timeslotIdIn[1], timeslotIdIn[0], txSerialData,
                             txFrameSync, txMultiframeSync, txSerialClockIn};

  always_ff @(posedge ref_clk)
  begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
    pinPrev_r <= pinSync_r;
  end

  wire logic serClkRise = pinSync_r[0] && !pinPrev_r[0];
  wire logic serClkFall = !pinSync_r[0] && pinPrev_r[0];
  wire logic fastClkRise = pinSync_r[1] && !pinPrev_r[1];
  wire logic fsyncLevel = pinSync_r[2] ^ syncLow;
  wire logic msyncLevel = pinSync_r[1];

  // Data is taken on the edge opposite the one on which it changes.
  wire logic baseSample = tic_r.clkInv ? serClkRise : serClkFall;
  wire logic sampleEdge = baseRate ? baseSample : (fastClkRise && !muxReserved);

  // ----------------------------------------------------------------------
  // Frame alignment for the multiplexed modes
  // ----------------------------------------------------------------------
  logic [10:0] bitCnt_r;
  logic [10:0] bitCnt_nxt;
  logic fsyncSeen_r;
  wire logic fsyncRise = fsyncLevel && !fsyncSeen_r;
  wire logic [10:0] leadCnt = !tic_r.mode[1] ? LEAD_BITMUX :
                              (tic_r.mode[0] ? LEAD_H100 : LEAD_HMVIP);

  assign bitCnt_nxt = fsyncRise ? leadCnt : 11'(bitCnt_r + 11'h001);

  // Bit-mux cycles channels every bit, byte-mux every eight bits.
  wire logic [1:0] chanSel = muxByte ? bitCnt_nxt[4:3] : bitCnt_nxt[1:0];
  // In bit-mux mode the frame starts on the very bit where sync rises, so the live level counts.
  wire logic muxFrameStart = tic_r.muxEn && (bitCnt_nxt == 11'h000) &&
                             (fsyncLevel || fsyncSeen_r);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bitCnt_r <= 11'h000;
      fsyncSeen_r <= 1'b0;
    end
    else if (sampleEdge)
    begin
      bitCnt_r <= bitCnt_nxt;
      fsyncSeen_r <= fsyncLevel;
    end
  end

  // ----------------------------------------------------------------------
  // Word toward the framer
  // ----------------------------------------------------------------------
  bp_word_t word_nxt;
  wire logic syncStart = tic_r.muxEn ? muxFrameStart : fsyncRise;

  always_comb
  begin
    word_nxt = '0;
    word_nxt.dataBit = pinSync_r[3];
    word_nxt.sigBit = (fracActive || !baseRate) ? pinSync_r[4] : 1'b0;
    word_nxt.fracBit = fracActive ? pinSync_r[5] : 1'b0;
    word_nxt.chan = tic_r.muxEn ? chanSel : 2'b00;
    word_nxt.frameStart = baseRate ? fsyncLevel : (syncStart && !superSel);
    word_nxt.superStart = baseRate ? msyncLevel : (syncStart && superSel);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      bpWord <= '0;
      bpWordValid <= 1'b0;
    end
    else
    begin
      bpWordValid <= sampleEdge;
      if (sampleEdge)
      begin
        bpWord <= word_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock outputs: 1.5625 MHz serial clock (640 ns period) and the fast fractional clock
  // ----------------------------------------------------------------------
  logic [7:0] serDiv_r;
  logic serClkGen_r;
  logic [7:0] fastDiv_r;
  logic fastClk_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      serDiv_r <= 8'h00;
      serClkGen_r <= 1'b0;
      fastDiv_r <= 8'h00;
      fastClk_r <= 1'b0;
    end
    else
    begin
      serDiv_r <= (serDiv_r == SERCLK_HALF_CNT) ? 8'h00 : 8'(serDiv_r + 8'h01);
      serClkGen_r <= (serDiv_r == SERCLK_HALF_CNT) ? !serClkGen_r : serClkGen_r;
      fastDiv_r <= (fastDiv_r == FAST_HALF_CNT) ? 8'h00 : 8'(fastDiv_r + 8'h01);
      fastClk_r <= (fastDiv_r == FAST_HALF_CNT) ? !fastClk_r : fastClk_r;
    end
  end

  // Serial clock may only drive in base rate; elsewhere the far end supplies it.
  assign txSerialClockOe = baseRate && pinCfg_r[PINCFG_CLKOUT_BIT];
  assign txSerialClockOut = serClkGen_r && !(payloadClk && framerOverheadBit);

  // ----------------------------------------------------------------------
  // Time-slot identifier pins
  // ----------------------------------------------------------------------
  wire logic sigInput = fracActive || !baseRate;
  assign timeslotIdOe = {1'b1, 1'b1, 1'b1, !fracActive, !sigInput};
  assign timeslotIdOut[0] = sigInput ? 1'b0 : framerChanNum[0];
  assign timeslotIdOut[1] = fracActive ? 1'b0 : framerChanNum[1];
  assign timeslotIdOut[2] = fracActive ? fastClk_r : framerChanNum[2];
  assign timeslotIdOut[3] = fracActive ? framerMultiframeFirst : framerChanNum[3];
  assign timeslotIdOut[4] = framerChanNum[4];

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [7:0] wByte_r;
  logic wLane_r;

  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire logic wrTic = awAddr_r == TIC_ADDR;
  wire logic wrFsel = awAddr_r == FSEL_ADDR;
  wire logic wrPin = awAddr_r == PINCFG_ADDR;
  wire logic wrStat = awAddr_r == STAT_ADDR;
  wire logic wrHit = wrTic || wrFsel || wrPin;

  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
    end
    else
    begin
      awHeld_r <= awTake || (awHeld_r && !doWrite);
      wHeld_r <= wTake || (wHeld_r && !doWrite);
      if (awTake)
      begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake)
      begin
        wByte_r <= s_axi_wdata[7:0];
        wLane_r <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tic_r <= TIC_RESET;
      fsel_r <= FSEL_RESET;
      pinCfg_r <= PINCFG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (doWrite && wLane_r && wrTic)
      begin
        tic_r <= tic_t'(wByte_r & 8'hBF);
      end
      if (doWrite && wLane_r && wrFsel)
      begin
        fsel_r <= wByte_r;
      end
      if (doWrite && wLane_r && wrPin)
      begin
        pinCfg_r <= wByte_r;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : (wrStat ? RESP_SLVERR : RESP_DECERR);
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Status shows the decoded mode so software can see what the pins are doing.
  wire logic [7:0] statusWord = {2'b00, muxReserved, muxByte, fracActive,
                                 tic_r.muxEn, highSpeed, baseRate};
  wire logic [7:0] rdByte = (s_axi_araddr == TIC_ADDR) ? tic_r :
                            (s_axi_araddr == FSEL_ADDR) ? fsel_r :
                            (s_axi_araddr == PINCFG_ADDR) ? pinCfg_r :
                            (s_axi_araddr == STAT_ADDR) ? statusWord : 8'h00;
  wire logic rdHit = (s_axi_araddr == TIC_ADDR) || (s_axi_araddr == FSEL_ADDR) ||
                     (s_axi_araddr == PINCFG_ADDR) || (s_axi_araddr == STAT_ADDR);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rdByte};
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: sim/tx_bp_asserts.sv
// Checker for the transmit backplane control, bound to its top module.
// Assumes one ref_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ns
module tx_bp_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txSerialClockIn,
  input wire logic txSerialClockOe,
  input wire logic txMultiframeSync,
  input wire logic [4:0] timeslotIdOut,
  input wire logic [4:0] timeslotIdOe,
  input wire logic [4:0] framerChanNum,
  input wire logic framerMultiframeFirst,
  input wire logic bpWordValid
);
  logic prevSer;
  logic prevMs;
  logic [5:0] edgeHist;
  // A taken bit must trace back to a clock-pin edge a few cycles earlier.
  wire pinEdge = (prevSer != txSerialClockIn) || (prevMs != txMultiframeSync);
  always_ff @(posedge ref_clk)
  begin
    prevSer <= txSerialClockIn;
    prevMs <= txMultiframeSync;
    edgeHist <= {edgeHist[4:0], pinEdge};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_time_a: assert property (wrTaken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  rd_resp_time_a: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  reset_pins_a: assert property (disable iff (1'b0) sys_rst |=> timeslotIdOe == 5'h1F && !txSerialClockOe)
    else $error("pin roles wrong after reset");
  word_pulse_a: assert property (bpWordValid |=> !bpWordValid)
    else $error("word valid too long");
  word_cause_a: assert property (bpWordValid |-> |edgeHist[4:1])
    else $error("word without clock edge");
  frac_pins_a: assert property (!timeslotIdOe[1] |-> timeslotIdOe[3:2] == 2'b11 && timeslotIdOut[3] == framerMultiframeFirst)
    else $error("fractional pin roles wrong");
  chan_pins_a: assert property (timeslotIdOe[1] |-> timeslotIdOut[4:1] == framerChanNum[4:1])
    else $error("channel number pins wrong");
endmodule
bind tx_backplane_mode_control tx_bp_asserts tx_bp_asserts_i (.ref_clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txSerialClockIn,
  .txSerialClockOe, .txMultiframeSync, .timeslotIdOut, .timeslotIdOe, .framerChanNum,
  .framerMultiframeFirst, .bpWordValid);

// file: sim/bp_partner.sv
// Model of the backplane equipment that feeds transmit serial data.
// Assumes the bench calls send once per frame; clock pins stay still between frames, except serClk, which keeps toggling while slowOn is set.
`timescale 1ns/1ns
module bp_partner (
  input wire logic slowOn,
  output logic serClk,
  output logic mSync,
  output logic fSync,
  output logic serData,
  output logic [4:0] tsIn
);
  initial
  begin
    serClk = 1'b0;
    mSync = 1'b0;
    fSync = 1'b0;
    serData = 1'b0;
    tsIn = 5'h0A;
  end
  // The slow serial clock keeps running in high-speed modes though no data rides on it.
  always
  begin
    #324;
    if (slowOn)
      serClk = !serClk;
  end
  // Data moves on the launch edge, so it is steady a half period before the sample edge.
  task automatic send(input logic [7:0] d, input logic hs, input logic inv, input logic sf);
    for (int i = 0; i < 8; i++)
    begin
      if (hs)
        mSync = 1'b0;
      else
        serClk = !inv;
      serData = d[7-i];
      fSync = (i == 0);
      if (!hs)
        mSync = sf && (i == 0);
      #40;
      if (hs)
        mSync = 1'b1;
      else
        serClk = inv;
      #40;
    end
    fSync = 1'b0;
    serData = !serData;
  endtask
endmodule

// file: sim/tb_tx_backplane_mode_control.sv
// Self-checking bench for the transmit backplane control.
// Assumes the partner drives the backplane pins asynchronously to ref_clk.
`timescale 1ns/1ns
module tb_tx_backplane_mode_control import tx_bp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] awAddr = '0, arAddr = '0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = '0, rData;
  logic awReady, wReady, bValid, arReady, rValid, serClk, mSync, fSync, serData, clkOut, clkOe;
  logic [1:0] bResp, rResp;
  logic [4:0] tsIn, tsOut, tsOe;
  logic [4:0] chanNum = 5'h15;
  logic ovhBit = 1'b0, mfFirst = 1'b0, hsOn = 1'b0;
  bp_word_t bpWord;
  logic bpWordValid;
  bp_word_t q[$];
  int error_cnt = 0, tests_run = 0;
  tx_backplane_mode_control tx_backplane_mode_control_i (.ref_clk, .sys_rst,
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .txSerialClockIn(serClk),
    .txSerialClockOut(clkOut), .txSerialClockOe(clkOe), .txMultiframeSync(mSync),
    .txFrameSync(fSync), .txSerialData(serData), .timeslotIdIn(tsIn), .timeslotIdOut(tsOut),
    .timeslotIdOe(tsOe), .framerChanNum(chanNum), .framerOverheadBit(ovhBit),
    .framerMultiframeFirst(mfFirst), .bpWord, .bpWordValid);
  bp_partner bp_partner_i (.slowOn(hsOn), .serClk, .mSync, .fSync, .serData, .tsIn);
  initial
    forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (bpWordValid === 1'b1)
      q.push_back(bpWord);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awReady)
        awValid <= 1'b0;
      if (wReady)
        wValid <= 1'b0;
    end
    while ((awValid && !awReady) || (wValid && !wReady));
    do @(posedge ref_clk); while (bValid !== 1'b1);
    bReady <= 1'b0;
    check(bResp, er, "bresp");
  endtask
  task automatic axi_rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge ref_clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (rValid !== 1'b1);
    rReady <= 1'b0;
    check(rData, ed, "rdata");
    check(rResp, er, "rresp");
  endtask
  task automatic frame(input logic [7:0] d, input logic hs, input logic inv, input logic sf);
    q.delete();
    // Pin changes stay clear of the ref_clk sampling edge.
    #1;
    bp_partner_i.send(d, hs, inv, sf);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic chk_frame(input logic [7:0] d, input logic fs, input logic ss, input logic mx);
    check(q.size(), 8, "word count");
    for (int i = 0; i < 8 && i < q.size(); i++)
    begin
      check(q[i].dataBit, d[7-i], "data bit");
      if (mx)
        check(q[i].chan, i % 4, "channel");
    end
    check(q[0].frameStart, fs, "frame start");
    check(q[0].superStart, ss, "super start");
  endtask
  task automatic t_regs();
    axi_rd(TIC_ADDR, 32'h0, RESP_OKAY);
    axi_wr(TIC_ADDR, 32'hFF, RESP_OKAY);
    axi_rd(TIC_ADDR, 32'hBF, RESP_OKAY);
    axi_rd(14'h0010, 32'h0, RESP_DECERR);
    axi_wr(TIC_ADDR, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_base();
    for (int v = 0; v < 2; v++)
    begin
      axi_wr(TIC_ADDR, 32'(v * 8), RESP_OKAY);
      frame(8'hA5 ^ 8'(v), 1'b0, v[0], v[0]);
      chk_frame(8'hA5 ^ 8'(v), 1'b1, v[0], 1'b0);
      check({clkOe, tsOe, tsOut}, {1'b0, 5'h1F, chanNum}, "base pins");
    end
    $display("test base done");
  endtask
  task automatic t_frac();
    int n;
    logic p;
    axi_wr(TIC_ADDR, 32'h10, RESP_OKAY);
    check(tsOe[3:0], 4'hC, "frac enables");
    mfFirst <= 1'b1;
    @(posedge ref_clk);
    check(tsOut[3], 1'b1, "overhead pin");
    mfFirst <= 1'b0;
    @(posedge ref_clk);
    check(tsOut[3], 1'b0, "overhead pin");
    n = 0;
    p = tsOut[2];
    repeat (64)
    begin
      @(posedge ref_clk);
      if (tsOut[2] !== p)
        n++;
      p = tsOut[2];
    end
    check(n inside {[15:17]}, 1'b1, "fast clock toggles");
    $display("test fractional done");
  endtask
  task automatic t_hs();
    hsOn <= 1'b1;
    for (int m = 1; m < 4; m++)
    begin
      axi_wr(FSEL_ADDR, (m == 3) ? 32'h20 : 32'h0, RESP_OKAY);
      axi_wr(TIC_ADDR, 32'(m + 24), RESP_OKAY);
      frame(8'h3C + 8'(m), 1'b1, 1'b0, 1'b0);
      chk_frame(8'h3C + 8'(m), m != 3, m == 3, 1'b0);
      check({tsOe[2], tsOe[0], tsOut[2]}, {2'b10, chanNum[2]}, "hs pins");
    end
    hsOn <= 1'b0;
    axi_wr(FSEL_ADDR, 32'h0, RESP_OKAY);
    $display("test high speed done");
  endtask
  task automatic t_mux();
    axi_wr(TIC_ADDR, 32'h04, RESP_OKAY);
    frame(8'h96, 1'b1, 1'b0, 1'b0);
    chk_frame(8'h96, 1'b1, 1'b0, 1'b1);
    axi_wr(TIC_ADDR, 32'h05, RESP_OKAY);
    frame(8'hF0, 1'b1, 1'b0, 1'b0);
    check(q.size(), 0, "reserved mode words");
    $display("test mux done");
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The whole run needs under 20 us, so a hang shows long before this fires.
  initial
  begin
    #200000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_base();
    t_frac();
    t_hs();
    t_mux();
    tally_and_finish();
  end
endmodule
